/* File: frac_consts.svh */
`ifndef FRAC_CONSTS_SVH
`define FRAC_CONSTS_SVH
// register offsets on the plain register port
`define OFF_REF_DIV 4'h2
`define OFF_INT_RATIO 4'h3
`define OFF_FRAC_VAL 4'h4
`define OFF_OSC_ACCESS 4'h5
`define OFF_MOD_CFG 4'h6
`define OFF_STEP_CNT 4'hc
`define OFF_STATUS 4'hf
// modulator configuration fields
`define MOD_EN_BIT 11
`define MOD_BYP_BIT 7
// reset values
`define RST_REG24 24'h000000
`define RST_REF_DIV 24'h000001
`define RST_INT_RATIO 24'h000014
`define RST_MOD_CFG 24'h000080
// integer ratio limits
`define INT_MIN_WHOLE 19'h00010
`define INT_MIN_FRAC 19'h00014
`define INT_MAX_FRAC 19'h7fffc
// oscillator side serial frame layout
`define OSC_FRAME_BITS 5'h10
`define OSC_ID_LSB 0
`define OSC_ADDR_LSB 3
`define OSC_DATA_LSB 7
`define OSC_OUTDIV_ADDR 4'h2
`define OSC_BUSY_BIT 23
`endif

/* File: frac_pkg.sv */
package frac_pkg;
  // one register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [23:0] wdata;
  } bus_req_type;
  // oscillator side serial port pins
  typedef struct packed {
    logic sen;
    logic sclk;
    logic sdata;
  } osc_port_type;
  // modulator state
  typedef struct packed {
    logic [23:0] acc;
    logic [23:0] step_cnt;
    logic carry;
  } mod_state_type;
  // controller state
  typedef struct packed {
    logic [23:0] ref_div;
    logic [23:0] int_ratio;
    logic [23:0] frac_val;
    logic [23:0] osc_access;
    logic [23:0] mod_cfg;
    logic [23:0] step_cnt;
    logic [18:0] act_int;
    logic [23:0] act_frac;
    logic [23:0] act_steps;
    logic act_frac_mode;
    logic [23:0] ref_cnt;
    logic [19:0] fb_cnt;
    logic [5:0] out_cnt;
    logic [5:0] out_div;
    logic [15:0] sh;
    logic [4:0] sh_left;
    logic osc_busy;
    osc_port_type osc;
    logic [23:0] rdata;
    logic pd_tick;
    logic fb_tick;
    logic out_tick;
  } ctl_state_type;
endpackage

/* File: sigma_modulator.sv */
`timescale 1ns/10ps
`default_nettype none
`include "frac_consts.svh"
// first order accumulator with full 24 bit modulus
module sigma_modulator
  import frac_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_update,
  input wire logic i_enable,
  input wire logic [23:0] i_frac,
  input wire logic [23:0] i_steps,
  output logic o_carry
);
  mod_state_type q; // registered state
  mod_state_type d; // next state
  logic [24:0] sum; // accumulator plus fraction

  // accumulate once per feedback update
  always_comb begin
    d = q;
    sum = {1'b0, q.acc} + {1'b0, i_frac};
    if (i_update) begin
      if (!i_enable) begin
        // integer mode: modulator held idle
        d.acc = `RST_REG24;
        d.step_cnt = `RST_REG24;
        d.carry = 1'b0;
      end else begin
        d.carry = sum[24];
        if ((i_steps != `RST_REG24) && (q.step_cnt >= i_steps - 24'h000001)) begin
          // plan of steps complete: restart phase, modulus stays 2^24
          d.acc = `RST_REG24;
          d.step_cnt = `RST_REG24;
        end else begin
          d.acc = sum[23:0];
          d.step_cnt = q.step_cnt + 24'h000001;
        end
      end
    end
  end

  // state register, frozen while clock enable is low
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_carry = q.carry;
endmodule // sigma_modulator
`default_nettype wire

/* File: frac_divider_ctl.sv */
// Notes on behaviour
// - integer mode: modulator idle, ratio 16 upward
// - reference divided by R gives detector tick
// - fraction register over 2^24 is fraction
// - fractional mode integer ratio kept 20..524284
// - output equals oscillator divided by k, odd k above one taken as k-1
// - oscillator registers written only through offset 5
// - normal step is detector rate over 2^24
// - step count restarts accumulator phase plan
// - accumulator keeps its full 24-bit modulus
`timescale 1ns/10ps
`default_nettype none
`include "frac_consts.svh"
module frac_divider_ctl
  import frac_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire bus_req_type i_bus,
  input wire logic i_ref_tick,
  input wire logic i_vco_tick,
  output logic [23:0] o_rdata,
  output logic o_pd_tick,
  output logic o_fb_tick,
  output logic o_out_tick,
  output osc_port_type o_osc
);
  ctl_state_type q; // registered state
  ctl_state_type d; // next state
  logic carry; // modulator carry, one extra feedback count
  logic frac_mode; // programmed mode is fractional
  logic [18:0] int_lim; // programmed integer ratio after limits
  logic [19:0] fb_ratio; // ratio for this feedback cycle
  logic [23:0] ref_last; // last reference count value
  logic [5:0] k_last; // last output divider count value
  logic osc_start; // a write to the access register is taken
  logic [3:0] osc_addr; // oscillator register address of a write
  logic [23:0] status; // live status word

  // modulator, updated on every feedback tick
  sigma_modulator u_mod (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_update(q.fb_tick),
    .i_enable(q.act_frac_mode),
    .i_frac(q.act_frac),
    .i_steps(q.act_steps),
    .o_carry(carry)
  );

  // decode of mode, ratio limits and divider terminal counts
  always_comb begin
    // fractional only with enable set and bypass clear
    frac_mode = q.mod_cfg[`MOD_EN_BIT] & ~q.mod_cfg[`MOD_BYP_BIT];
    int_lim = q.int_ratio[18:0];
    if (frac_mode) begin
      // fractional path limits
      if (int_lim < `INT_MIN_FRAC) begin
        int_lim = `INT_MIN_FRAC;
      end else if (int_lim > `INT_MAX_FRAC) begin
        int_lim = `INT_MAX_FRAC;
      end
    end else if (int_lim < `INT_MIN_WHOLE) begin
      // whole number path lower limit
      int_lim = `INT_MIN_WHOLE;
    end
    // zero reference divide acts as one
    if (q.ref_div == `RST_REG24) begin
      ref_last = `RST_REG24;
    end else begin
      ref_last = q.ref_div - 24'h000001;
    end
    // odd settings above one round down to even
    if (q.out_div <= 6'h01) begin
      k_last = 6'h00;
    end else begin
      k_last = {q.out_div[5:1], 1'b0} - 6'h01;
    end
    // active integer plus any modulator carry
    fb_ratio = {1'b0, q.act_int} + {19'h00000, carry};
    osc_addr = i_bus.wdata[`OSC_ADDR_LSB +: 4];
    osc_start = i_bus.wr && (i_bus.addr == `OFF_OSC_ACCESS) && !q.osc_busy;
    status = {21'h000000, q.osc_busy, q.act_steps != `RST_REG24, q.act_frac_mode};
  end

  // next state of the whole block
  always_comb begin
    d = q;
    d.pd_tick = 1'b0;
    d.fb_tick = 1'b0;
    d.out_tick = 1'b0;
    d.rdata = `RST_REG24;

    // register writes
    if (i_bus.wr) begin
      case (i_bus.addr)
        `OFF_REF_DIV: begin
          d.ref_div = i_bus.wdata;
        end
        `OFF_INT_RATIO: begin
          d.int_ratio = i_bus.wdata;
        end
        `OFF_FRAC_VAL: begin
          d.frac_val = i_bus.wdata;
        end
        `OFF_MOD_CFG: begin
          d.mod_cfg = i_bus.wdata;
        end
        `OFF_STEP_CNT: begin
          d.step_cnt = i_bus.wdata;
        end
        default: begin
          // other offsets ignore writes here, offset 5 is taken by the serial port below
        end
      endcase
    end

    // register reads, data in the following cycle
    if (i_bus.rd) begin
      case (i_bus.addr)
        `OFF_REF_DIV: begin
          d.rdata = q.ref_div;
        end
        `OFF_INT_RATIO: begin
          d.rdata = q.int_ratio;
        end
        `OFF_FRAC_VAL: begin
          d.rdata = q.frac_val;
        end
        `OFF_OSC_ACCESS: begin
          d.rdata = q.osc_access;
          d.rdata[`OSC_BUSY_BIT] = q.osc_busy;
        end
        `OFF_MOD_CFG: begin
          d.rdata = q.mod_cfg;
        end
        `OFF_STEP_CNT: begin
          d.rdata = q.step_cnt;
        end
        `OFF_STATUS: begin
          d.rdata = status;
        end
        default: begin
          // unmapped reads return zero
          d.rdata = `RST_REG24;
        end
      endcase
    end

    // reference divider forms the detector tick
    if (i_ref_tick) begin
      if (q.ref_cnt >= ref_last) begin
        d.ref_cnt = `RST_REG24;
        d.pd_tick = 1'b1;
      end else begin
        d.ref_cnt = q.ref_cnt + 24'h000001;
      end
    end

    // feedback divider counts oscillator edges
    if (i_vco_tick) begin
      if (q.fb_cnt + 20'h00001 >= fb_ratio) begin
        d.fb_cnt = 20'h00000;
        d.fb_tick = 1'b1;
      end else begin
        d.fb_cnt = q.fb_cnt + 20'h00001;
      end
    end

    // ratios take effect together at the modulator update
    if (q.fb_tick) begin
      d.act_int = int_lim;
      d.act_frac_mode = frac_mode;
      // whole number mode drops the fraction entirely
      d.act_frac = frac_mode ? q.frac_val : `RST_REG24;
      d.act_steps = frac_mode ? q.step_cnt : `RST_REG24;
    end

    // output divider on oscillator edges
    if (i_vco_tick) begin
      if (q.out_cnt >= k_last) begin
        d.out_cnt = 6'h00;
        d.out_tick = 1'b1;
      end else begin
        d.out_cnt = q.out_cnt + 6'h01;
      end
    end

    // oscillator side serial port, two cycles per bit
    if (osc_start) begin
      // accept the frame and load the shifter
      d.osc_access = i_bus.wdata;
      d.sh = i_bus.wdata[15:0];
      d.sh_left = `OSC_FRAME_BITS;
      d.osc_busy = 1'b1;
      d.osc.sen = 1'b1;
      d.osc.sclk = 1'b0;
      d.osc.sdata = i_bus.wdata[15];
      // local copy of the output divider setting
      if ((i_bus.wdata[`OSC_ID_LSB +: 3] == 3'h0) && (osc_addr == `OSC_OUTDIV_ADDR)) begin
        d.out_div = i_bus.wdata[`OSC_DATA_LSB +: 6];
      end
    end else if (q.osc_busy) begin
      if (!q.osc.sclk) begin
        // rising edge, far side samples the bit
        d.osc.sclk = 1'b1;
      end else if (q.sh_left == 5'h01) begin
        // last bit done, end the frame
        d.osc.sclk = 1'b0;
        d.osc.sen = 1'b0;
        d.osc.sdata = 1'b0;
        d.osc_busy = 1'b0;
        d.sh_left = 5'h00;
      end else begin
        // falling edge, present the next bit
        d.osc.sclk = 1'b0;
        d.sh = {q.sh[14:0], 1'b0};
        d.osc.sdata = q.sh[14];
        d.sh_left = q.sh_left - 5'h01;
      end
    end
  end

  // state register, frozen while clock enable is low
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '0;
      q.ref_div <= `RST_REF_DIV;
      q.int_ratio <= `RST_INT_RATIO;
      q.mod_cfg <= `RST_MOD_CFG;
      q.act_int <= `INT_MIN_FRAC;
    end else if (i_ce) begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign o_rdata = q.rdata;
  assign o_pd_tick = q.pd_tick;
  assign o_fb_tick = q.fb_tick;
  assign o_out_tick = q.out_tick;
  assign o_osc = q.osc;
endmodule // frac_divider_ctl
`default_nettype wire

/* File: frac_divider_ctl_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module frac_divider_ctl_monitor
  import frac_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire bus_req_type i_bus,
  input wire logic i_ref_tick,
  input wire logic i_vco_tick,
  input wire logic [23:0] o_rdata,
  input wire logic o_pd_tick,
  input wire logic o_fb_tick,
  input wire logic o_out_tick,
  input wire osc_port_type o_osc
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic [5:0] sen_q; // cycles of the current serial frame
  logic [19:0] vco_q; // oscillator ticks since the last feedback pulse
  // helper counters, frozen with the block when enable is low
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sen_q <= 6'h00;
      vco_q <= 20'h00000;
    end else if (i_ce) begin
      sen_q <= o_osc.sen ? sen_q + 6'h01 : 6'h00;
      vco_q <= (o_fb_tick ? 20'h00000 : vco_q) + {19'h00000, i_vco_tick};
    end
  end
  pd_cause_a: assert property (o_pd_tick |-> $past(i_ref_tick)) else $error("detector pulse without tick");
  fb_cause_a: assert property (o_fb_tick |-> $past(i_vco_tick)) else $error("feedback pulse without tick");
  fb_min_a: assert property (o_fb_tick |-> vco_q >= 20'h00010) else $error("feedback ratio below 16");
  out_cause_a: assert property (o_out_tick |-> $past(i_vco_tick)) else $error("output pulse without tick");
  osc_start_a: assert property ($rose(o_osc.sen) |-> !o_osc.sclk && $past(i_bus.wr && i_bus.addr == 4'h5))
    else $error("frame not started by offset 5 write");
  osc_len_a: assert property ($fell(o_osc.sen) |-> sen_q == 6'h20) else $error("frame not 32 cycles");
  osc_idle_a: assert property (!o_osc.sen |-> !o_osc.sclk && !o_osc.sdata) else $error("serial pins not idle");
  sclk_toggle_a: assert property (o_osc.sen && $past(o_osc.sen) && $past(i_ce)
    |-> o_osc.sclk != $past(o_osc.sclk)) else $error("serial clock stuck");
  sdata_hold_a: assert property (o_osc.sclk |-> $stable(o_osc.sdata)) else $error("data moved on clock high");
  cover property (o_fb_tick);
  cover property ($fell(o_osc.sen));
  cover property (o_out_tick);
endmodule // frac_divider_ctl_monitor
bind frac_divider_ctl frac_divider_ctl_monitor mon (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
  .i_bus(i_bus), .i_ref_tick(i_ref_tick), .i_vco_tick(i_vco_tick), .o_rdata(o_rdata), .o_pd_tick(o_pd_tick),
  .o_fb_tick(o_fb_tick), .o_out_tick(o_out_tick), .o_osc(o_osc));
`default_nettype wire

/* File: frac_divider_ctl_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module frac_divider_ctl_tb_top import frac_pkg::*; ;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_ce = 1'b1; // enable, dropped only by the freeze scenario
  logic i_ref_tick = 1'b0;
  logic i_vco_tick = 1'b0;
  bus_req_type i_bus = '0;
  logic [23:0] o_rdata;
  logic o_pd_tick;
  logic o_fb_tick;
  logic o_out_tick;
  osc_port_type o_osc;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int bits = 0; // serial bits seen
  logic [15:0] cap_q = 16'h0000; // captured serial word
  logic [23:0] v;
  int n;
  frac_divider_ctl dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_bus(i_bus), .i_ref_tick(i_ref_tick),
    .i_vco_tick(i_vco_tick), .o_rdata(o_rdata), .o_pd_tick(o_pd_tick), .o_fb_tick(o_fb_tick),
    .o_out_tick(o_out_tick), .o_osc(o_osc));
  initial forever #4 i_clk = ~i_clk;
  // data is stable while the serial clock is high
  always @(posedge o_osc.sclk) begin
    cap_q = {cap_q[14:0], o_osc.sdata};
    bits++;
  end
  // hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      fails++;
    end
  endtask
  // one cycle write strobe, released at the edge that takes it
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge i_clk);
    i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    i_bus <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [23:0] d);
    @(posedge i_clk);
    i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 24'h000000};
    @(posedge i_clk);
    i_bus <= '0;
    #1 d = o_rdata;
  endtask
  function automatic logic pulse(input int sel);
    return sel == 0 ? o_pd_tick : sel == 1 ? o_fb_tick : o_out_tick;
  endfunction
  // cycles spanned by np pulse periods of the chosen output
  task automatic span(input int sel, input int np, output int c);
    int g;
    g = 0;
    c = 0;
    do begin @(posedge i_clk); #1 g++; end while (!pulse(sel) && g < 500);
    repeat (np) begin
      do begin @(posedge i_clk); #1 c++; end while (!pulse(sel) && c < 500);
    end
  endtask
  // reset values, one unmapped offset
  task automatic t_reset();
    logic [3:0] a [7] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hc, 4'h7};
    logic [23:0] e [7] = '{24'h000001, 24'h000014, 24'h0, 24'h0, 24'h000080, 24'h0, 24'h0};
    for (int i = 0; i < 7; i++) begin
      rd(a[i], v);
      check(v, e[i]);
    end
  endtask
  // detector divide by 3, then by 0 acting as 1
  task automatic t_pd();
    wr(4'h2, 24'h000003);
    rd(4'h2, v);
    check(v, 24'h000003);
    span(0, 2, n);
    span(0, 2, n);
    check(24'(n), 24'h000006);
    wr(4'h2, 24'h000000);
    span(0, 2, n);
    span(0, 2, n);
    check(24'(n), 24'h000002);
  endtask
  // clock enable low freezes the block, so a write then is lost
  task automatic t_ce();
    @(posedge i_clk);
    i_ce <= 1'b0;
    wr(4'h2, 24'h000005);
    i_ce <= 1'b1;
    rd(4'h2, v);
    check(v, 24'h000000);
  endtask
  // ratio in force after the next feedback update
  task automatic fb(input logic [23:0] cfg, input logic [23:0] nint, input int np, input logic [23:0] exp);
    wr(4'h6, cfg);
    wr(4'h3, nint);
    span(1, 2, n);
    span(1, np, n);
    check(24'(n), exp);
  endtask
  task automatic t_modes();
    wr(4'h4, 24'h800000);
    fb(24'h000080, 24'h000010, 1, 24'h000010);
    fb(24'h000080, 24'h00000c, 1, 24'h000010);
    fb(24'h000880, 24'h000012, 1, 24'h000012);
    rd(4'hf, v);
    check(v & 24'h000001, 24'h000000);
    fb(24'h000800, 24'h000012, 2, 24'h000029);
    rd(4'hf, v);
    check(v & 24'h000003, 24'h000001);
    wr(4'hc, 24'h00000a);
    fb(24'h000800, 24'h000014, 2, 24'h000029);
    rd(4'hf, v);
    check(v & 24'h000003, 24'h000003);
    // host plan: offset of a third of the detector rate, three steps, floor 22
    wr(4'hc, 24'h000003);
    wr(4'h4, 24'h555556);
    span(1, 3, n);
    fb(24'h000800, 24'h000016, 3, 24'h000043);
  endtask
  // output divider through offset 5, second write dropped while busy
  task automatic t_osc(input logic [23:0] w, input logic [23:0] k);
    int g;
    bits = 0;
    wr(4'h5, w);
    wr(4'h5, 24'h00ffff);
    rd(4'h5, v);
    check(v, w | 24'h800000);
    g = 0;
    do begin @(posedge i_clk); #1 g++; end while (o_osc.sen && g < 100);
    check({8'h00, cap_q}, w);
    check(24'(bits), 24'h000010);
    rd(4'h5, v);
    check(v, w);
    span(2, 1, n);
    span(2, 1, n);
    check(24'(n), k);
  endtask
  task automatic report_and_stop();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    i_ref_tick <= 1'b1;
    i_vco_tick <= 1'b1;
    t_reset();
    t_pd();
    t_ce();
    t_modes();
    t_osc(24'h000210, 24'h000004);
    t_osc(24'h001f10, 24'h00003e);
    report_and_stop();
  end
endmodule // frac_divider_ctl_tb_top
`default_nettype wire
